// ---- bench/mfs_bridge_model.sv ----
// partner model: inverter bridge, shunt and converter sequence of one pwm period
// assumes the bench sets the shunt levels and shares sys_clk and rst_n
`include "mfs_defs.svh"
module mfs_bridge_model
#(
    parameter int PERIOD = 24
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [11:0] shunt1,
    input wire logic [11:0] shunt2,
    input wire logic [11:0] shuntZero,
    output logic fastTick,
    output logic slowTick,
    output logic [2:0] activeSector,
    output logic [2:0] activeVector,
    output logic smpValid,
    output logic [11:0] smpData
);
    timeunit 1ns;
    timeprecision 100ps;
    int cnt;
    int per;
    logic [11:0] lastData;
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt <= 1;
            per <= 0;
            lastData <= 12'h000;
        end
        else
        begin
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            per <= (cnt == PERIOD - 1) ? per + 1 : per;
            lastData <= smpData;
        end
    end
    always_comb
    begin
        fastTick = rst_n && cnt == 0;
        slowTick = rst_n && cnt == 12 && per[1:0] == 2'h0;
        activeSector = 3'(per % 6 + 1);
        activeVector = (cnt == 2) ? `MFS_VEC_TOP : (cnt > 12) ? `MFS_VEC_BOTTOM : 3'b100;
        smpValid = rst_n && cnt < `MFS_NUM_SLOTS;
        case (cnt)
            0: smpData = shunt1;
            1: smpData = shunt2;
            2: smpData = shuntZero;
            default: smpData = (cnt < 10) ? 12'h100 + 12'(cnt) : ~lastData;
        endcase
    end
endmodule

// ---- bench/tb_motor_run_freewheel_shunt_sampling.sv ----
// bench: bus tasks, sequencer walk and current rebuilding checks
// assumes mfs_core with a short coast count and the bridge model beside it
`include "mfs_defs.svh"
module tb_motor_run_freewheel_shunt_sampling
    import mfs_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk, rst_n, wbCyc, wbStb, wbWe, wbAck, diagFault, alignDone, mergeReached, highReached;
    logic [7:0] wbAdr;
    logic [3:0] wbSel;
    logic [31:0] wbDatI, wbDatO, rdat;
    logic fastTick, slowTick, smpValid, pwmEnable, calDrive50, runCurrentCtrl, runSpeedCtrl;
    logic runEstimator, runActuation, diagFull, diagBasic, estAtTick, ctlAtTick;
    logic [2:0] activeSector, activeVector;
    logic [11:0] smpData, shunt1, shunt2, shuntZero;
    logic [3:0] slotIndex;
    logic signed [13:0] currentA, currentB, currentC;
    int errTotal = 0;
    int comparisons = 0;
    mfs_core #(.COAST_TICKS(16'd4)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
        .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .fastTick(fastTick), .slowTick(slowTick),
        .diagFault(diagFault), .alignDone(alignDone), .mergeReached(mergeReached),
        .highReached(highReached), .activeSector(activeSector), .activeVector(activeVector),
        .smpValid(smpValid), .smpData(smpData), .pwmEnable(pwmEnable), .calDrive50(calDrive50),
        .runCurrentCtrl(runCurrentCtrl), .runSpeedCtrl(runSpeedCtrl), .runEstimator(runEstimator),
        .runActuation(runActuation), .diagFull(diagFull), .diagBasic(diagBasic),
        .slotIndex(slotIndex), .currentA(currentA), .currentB(currentB), .currentC(currentC));
    mfs_bridge_model partner_u (.sys_clk(sys_clk), .rst_n(rst_n), .shunt1(shunt1), .shunt2(shunt2),
        .shuntZero(shuntZero), .fastTick(fastTick), .slowTick(slowTick), .activeSector(activeSector),
        .activeVector(activeVector), .smpValid(smpValid), .smpData(smpData));
    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errTotal++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        @(posedge sys_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbDatI <= wd;
        do
            @(posedge sys_clk);
        while (wbAck !== 1'b1);
        rdat = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] adr, input logic [31:0] mask, input logic [31:0] exp);
        wb_cycle(1'b0, adr, 32'h0);
        chk(rdat & mask, exp);
    endtask
    task automatic wait_tick(input int k);
        repeat (k)
        begin
            do
                @(posedge sys_clk);
            while (fastTick !== 1'b1);
            estAtTick = runEstimator;
            ctlAtTick = runCurrentCtrl;
        end
        #1;
    endtask
    task automatic cur_chk(input logic signed [13:0] a, input logic signed [13:0] b);
        chk(32'(currentA), 32'(a));
        chk(32'(currentB), 32'(b));
        chk(32'(currentC), 32'(-(a + b)));
    endtask
    task automatic print_verdict();
        $display("comparisons=%0d errors=%0d", comparisons, errTotal);
        if (errTotal == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ****************************************
    // clock, reset and tests
    // ****************************************
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        errTotal++;
        print_verdict();
    end
    initial
    begin
        int n;
        {rst_n, wbCyc, wbStb, wbWe, diagFault, alignDone, mergeReached, highReached} = 8'h00;
        wbAdr = 8'h00;
        wbSel = 4'hf;
        wbDatI = 32'h0;
        shunt1 = 12'h8a0;
        shunt2 = 12'h770;
        shuntZero = 12'h800;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd(`MFS_ADDR_STATUS, 32'h1ff, 32'(ST_STOP));
        rd(`MFS_ADDR_COAST, 32'hffff, 32'h4);
        wb_cycle(1'b1, 8'h20, 32'hffffffff);
        rd(8'h20, 32'hffffffff, 32'h0);
        wb_cycle(1'b1, `MFS_ADDR_COAST, 32'h5);
        rd(`MFS_ADDR_COAST, 32'hffff, 32'h5);
        $display("test registers done");
        wait_tick(3);
        chk(32'(pwmEnable), 32'h0);
        cur_chk(14'sd160, -14'sd144);
        chk(32'(slotIndex), 32'h1);
        rd(`MFS_ADDR_CURAB, 32'hffffffff, {16'(-14'sd144), 16'(14'sd160)});
        for (int i = 2; i < 10; i++)
            rd(8'(`MFS_ADDR_SAMPLE + 4 * i), 32'hfff, (i == 2) ? 32'h800 : 32'h100 + i);
        $display("test sampling done");
        shunt1 <= 12'h810;
        shunt2 <= 12'h7f8;
        wait_tick(2);
        wb_cycle(1'b1, `MFS_ADDR_CTRL, 32'h1);
        wait_tick(1);
        rd(`MFS_ADDR_STATUS, 32'h7, 32'(ST_ALIGN));
        wait_tick(1);
        chk(32'({calDrive50, pwmEnable}), 32'h3);
        @(posedge sys_clk);
        alignDone <= 1'b1;
        wait_tick(9);
        rd(`MFS_ADDR_STATUS, 32'h1ff, 32'h1f8 | 32'(ST_LOW));
        shunt1 <= 12'h8a0;
        shunt2 <= 12'h770;
        wait_tick(3);
        cur_chk(14'sd144, -14'sd136);
        chk(32'({runActuation, ctlAtTick}), 32'h3);
        @(posedge sys_clk);
        mergeReached <= 1'b1;
        highReached <= 1'b1;
        wait_tick(2);
        rd(`MFS_ADDR_STATUS, 32'h7, 32'(ST_HIGH));
        wait_tick(1);
        chk(32'({diagFull, ctlAtTick, estAtTick}), 32'h7);
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (slowTick !== 1'b1 && n < 200);
        chk(32'(runSpeedCtrl), 32'h1);
        $display("test run up done");
        wait_tick(1);
        wb_cycle(1'b1, `MFS_ADDR_CTRL, 32'h2);
        rd(`MFS_ADDR_STATUS, 32'h7, 32'(ST_HIGH));
        wait_tick(1);
        chk(32'(pwmEnable), 32'h0);
        rd(`MFS_ADDR_STATUS, 32'h1fffe07, (32'h5 << 9) | 32'(ST_FREE));
        wait_tick(1);
        chk(32'({ctlAtTick, estAtTick, diagFull, diagBasic, pwmEnable}), 32'h2);
        wait_tick(3);
        rd(`MFS_ADDR_STATUS, 32'h7, 32'(ST_FREE));
        wait_tick(1);
        rd(`MFS_ADDR_STATUS, 32'h1ff, 32'(ST_STOP));
        $display("test freewheel done");
        wb_cycle(1'b1, `MFS_ADDR_CTRL, 32'h1);
        wait_tick(12);
        rd(`MFS_ADDR_STATUS, 32'h7, 32'(ST_HIGH));
        @(posedge sys_clk);
        diagFault <= 1'b1;
        #1;
        chk(32'(pwmEnable), 32'h0);
        wait_tick(1);
        rd(`MFS_ADDR_STATUS, 32'h1ff, 32'(ST_FAULT));
        diagFault <= 1'b0;
        wait_tick(1);
        rd(`MFS_ADDR_STATUS, 32'h7, 32'(ST_STOP));
        $display("test fault done");
        print_verdict();
    end
endmodule

// ---- include/mfs_defs.svh ----
// constants of the run/freewheel sequencer and single-shunt current sampler
// assumes a 125 MHz sys_clk and a classic Wishbone master with 32-bit data
`ifndef MFS_DEFS_SVH
`define MFS_DEFS_SVH
`define MFS_ADDR_CTRL 8'h00
`define MFS_ADDR_COAST 8'h04
`define MFS_ADDR_STATUS 8'h08
`define MFS_ADDR_CURAB 8'h0c
`define MFS_ADDR_CURC 8'h10
`define MFS_ADDR_SAMPLE 8'h40
`define MFS_CTRL_START 0
`define MFS_CTRL_STOP 1
`define MFS_COAST_TICKS 16'd16000
`define MFS_SLOT_SHUNT1 4'd0
`define MFS_SLOT_SHUNT2 4'd1
`define MFS_SLOT_OFFSET 4'd2
`define MFS_SLOT_REFLOW 4'd3
`define MFS_SLOT_REFHIGH 4'd4
`define MFS_SLOT_BANDGAP 4'd5
`define MFS_SLOT_TEMPINV 4'd6
`define MFS_SLOT_TEMPMED 4'd7
`define MFS_SLOT_TEMPCTL 4'd8
`define MFS_SLOT_BUSVOLT 4'd9
`define MFS_NUM_SLOTS 10
`define MFS_NUM_SECTORS 6
`define MFS_VEC_BOTTOM 3'b000
`define MFS_VEC_TOP 3'b111
`define MFS_ZERO_MV 1650
`endif

// ---- include/mfs_pkg.sv ----
// types of the run/freewheel sequencer and single-shunt current sampler
// assumes mfs_defs.svh is on the include path
package mfs_pkg;
    // fixed encoding: declaration order sets the code
    typedef enum logic [2:0] {
        ST_STOP,
        ST_ALIGN,
        ST_LOW,
        ST_MERGE,
        ST_HIGH,
        ST_FREE,
        ST_FAULT
    } mfs_state_type;
endpackage

// ---- verilog/mfs_core.sv ----
// motor run/freewheel sequencer with single-shunt current rebuilding
// assumes tick, fault, sector and sample inputs come from logic on sys_clk
`include "mfs_defs.svh"
module mfs_core
    import mfs_pkg::*;
#(
    parameter int SAMPLE_W = 12,
    parameter logic [15:0] COAST_TICKS = `MFS_COAST_TICKS
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic fastTick,
    input wire logic slowTick,
    input wire logic diagFault,
    input wire logic alignDone,
    input wire logic mergeReached,
    input wire logic highReached,
    input wire logic [2:0] activeSector,
    input wire logic [2:0] activeVector,
    input wire logic smpValid,
    input wire logic [SAMPLE_W-1:0] smpData,
    output logic pwmEnable,
    output logic calDrive50,
    output logic runCurrentCtrl,
    output logic runSpeedCtrl,
    output logic runEstimator,
    output logic runActuation,
    output logic diagFull,
    output logic diagBasic,
    output logic [3:0] slotIndex,
    output logic signed [SAMPLE_W+1:0] currentA,
    output logic signed [SAMPLE_W+1:0] currentB,
    output logic signed [SAMPLE_W+1:0] currentC
);
    if (SAMPLE_W < 8 || SAMPLE_W > 14)
    begin
        $error("SAMPLE_W must lie in 8..14");
    end

    localparam int CW = SAMPLE_W + 2;

    // ****************************************
    // state record
    // ****************************************
    typedef struct packed {
        mfs_state_type state;
        logic [15:0] coastCfg;
        logic [15:0] coast;
        logic [3:0] slot;
        logic [`MFS_NUM_SLOTS-1:0][SAMPLE_W-1:0] smp;
        logic [1:0][`MFS_NUM_SECTORS-1:0][CW-1:0] offs;
        logic [`MFS_NUM_SECTORS-1:0] calDone;
        logic [CW-1:0] curA;
        logic [CW-1:0] curB;
        logic [CW-1:0] curC;
        logic startReq;
        logic stopReq;
        logic actStrobe;
        logic ack;
        logic [31:0] rdata;
    } mfs_regs_type;

    mfs_regs_type r;
    mfs_regs_type next_r;
    logic rstMeta;
    logic rstSync;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [2:0] sectorIdx(input logic [2:0] sec);
        sectorIdx = (sec >= 3'd1 && sec <= 3'd6) ? sec - 3'd1 : 3'd0;
    endfunction

    function automatic logic [CW-1:0] shuntCur(input logic [SAMPLE_W-1:0] s,
        input logic [SAMPLE_W-1:0] z, input logic [CW-1:0] o);
        shuntCur = CW'({2'b00, s}) - CW'({2'b00, z}) - o;
    endfunction

    // ****************************************
    // reset release
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end
        else
        begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    // ****************************************
    // next state
    // ****************************************
    logic busReq;
    logic [2:0] secI;
    logic [CW-1:0] i1;
    logic [CW-1:0] i2;
    logic speedState;

    always_comb
    begin
        next_r = r;
        busReq = wb_cyc_i && wb_stb_i && !r.ack;
        secI = sectorIdx(activeSector);
        speedState = (r.state == ST_LOW) || (r.state == ST_MERGE) || (r.state == ST_HIGH);
        // startup offset applies only in the speed states, by sector
        i1 = shuntCur(r.smp[`MFS_SLOT_SHUNT1], r.smp[`MFS_SLOT_OFFSET],
            speedState ? r.offs[0][secI] : '0);
        i2 = shuntCur(r.smp[`MFS_SLOT_SHUNT2], r.smp[`MFS_SLOT_OFFSET],
            speedState ? r.offs[1][secI] : '0);
        next_r.actStrobe = 1'b0;
        // sample stream, slot order fixed, period restarts on fast tick
        if (fastTick)
            next_r.slot = (smpValid) ? 4'd1 : 4'd0;
        else if (smpValid && r.slot < 4'(`MFS_NUM_SLOTS))
            next_r.slot = r.slot + 4'd1;
        if (smpValid && (fastTick || r.slot < 4'(`MFS_NUM_SLOTS)))
            next_r.smp[fastTick ? 4'd0 : r.slot] = smpData;
        // current rebuilding in every state
        if (fastTick)
        begin
            next_r.curA = i1;
            next_r.curB = i2;
            next_r.curC = CW'(-(i1 + i2));
        end
        // startup offsets recorded during alignment, once per sector, zero current expected
        if (fastTick && r.state == ST_ALIGN && activeVector != `MFS_VEC_BOTTOM && !r.calDone[secI])
        begin
            next_r.offs[0][secI] = shuntCur(r.smp[`MFS_SLOT_SHUNT1], r.smp[`MFS_SLOT_OFFSET], '0);
            next_r.offs[1][secI] = shuntCur(r.smp[`MFS_SLOT_SHUNT2], r.smp[`MFS_SLOT_OFFSET], '0);
            next_r.calDone[secI] = 1'b1;
        end
        // state machine, transitions only on the fast tick
        if (fastTick)
        begin
            if (r.state == ST_HIGH || r.state == ST_LOW || r.state == ST_MERGE || r.state == ST_ALIGN)
                next_r.actStrobe = 1'b1;
            if (diagFault && r.state != ST_FAULT)
            begin
                next_r.state = ST_FAULT;
                next_r.coast = '0;
                next_r.calDone = '0;
                next_r.startReq = 1'b0;
                next_r.stopReq = 1'b0;
            end
            else
            begin
                unique case (r.state)
                    ST_STOP:
                    begin
                        if (r.startReq)
                        begin
                            next_r.state = ST_ALIGN;
                            next_r.calDone = '0;
                        end
                    end
                    ST_ALIGN:
                    begin
                        if (r.stopReq)
                            next_r.state = ST_STOP;
                        else if (alignDone && (&r.calDone))
                            next_r.state = ST_LOW;
                    end
                    ST_LOW:
                    begin
                        if (r.stopReq)
                        begin
                            next_r.state = ST_FREE;
                            next_r.coast = r.coastCfg;
                        end
                        else if (mergeReached)
                            next_r.state = ST_MERGE;
                    end
                    ST_MERGE:
                    begin
                        if (r.stopReq)
                        begin
                            next_r.state = ST_FREE;
                            next_r.coast = r.coastCfg;
                        end
                        else if (highReached)
                            next_r.state = ST_HIGH;
                    end
                    ST_HIGH:
                    begin
                        if (r.stopReq)
                        begin
                            next_r.state = ST_FREE;
                            next_r.coast = r.coastCfg;
                        end
                    end
                    ST_FREE:
                    begin
                        if (r.coast <= 16'd1)
                        begin
                            next_r.state = ST_STOP;
                            next_r.coast = '0;
                            next_r.calDone = '0;
                        end
                        else
                            next_r.coast = r.coast - 16'd1;
                    end
                    ST_FAULT:
                    begin
                        if (!diagFault)
                            next_r.state = ST_STOP;
                    end
                endcase
                next_r.startReq = 1'b0;
                next_r.stopReq = 1'b0;
            end
        end
        // register bus
        next_r.ack = busReq;
        next_r.rdata = '0;
        if (wb_cyc_i && wb_stb_i && wb_we_i && r.ack)
        begin
            if (wb_adr_i == `MFS_ADDR_CTRL && wb_sel_i[0])
            begin
                if (wb_dat_i[`MFS_CTRL_START])
                    next_r.startReq = 1'b1;
                if (wb_dat_i[`MFS_CTRL_STOP])
                    next_r.stopReq = 1'b1;
            end
            if (wb_adr_i == `MFS_ADDR_COAST)
            begin
                if (wb_sel_i[0])
                    next_r.coastCfg[7:0] = wb_dat_i[7:0];
                if (wb_sel_i[1])
                    next_r.coastCfg[15:8] = wb_dat_i[15:8];
            end
        end
        if (busReq && !wb_we_i)
        begin
            if (wb_adr_i == `MFS_ADDR_COAST)
                next_r.rdata = {16'h0000, r.coastCfg};
            else if (wb_adr_i == `MFS_ADDR_STATUS)
                next_r.rdata = {7'h00, r.coast, r.calDone, r.state};
            else if (wb_adr_i == `MFS_ADDR_CURAB)
                next_r.rdata = {16'(signed'(r.curB)), 16'(signed'(r.curA))};
            else if (wb_adr_i == `MFS_ADDR_CURC)
                next_r.rdata = {16'h0000, 16'(signed'(r.curC))};
            else if (wb_adr_i >= `MFS_ADDR_SAMPLE && wb_adr_i < `MFS_ADDR_SAMPLE + 8'(4 * `MFS_NUM_SLOTS)
                && wb_adr_i[1:0] == 2'b00)
                next_r.rdata = 32'(r.smp[4'((wb_adr_i - `MFS_ADDR_SAMPLE) >> 2)]);
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge sys_clk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            r <= '0;
            r.state <= ST_STOP;
            r.coastCfg <= COAST_TICKS;
        end
        else
        begin
            r <= next_r;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign wb_ack_o = r.ack;
    assign wb_dat_o = r.rdata;
    assign pwmEnable = (r.state == ST_ALIGN || speedState) && !diagFault;
    assign calDrive50 = (r.state == ST_ALIGN) && !(&r.calDone);
    assign runCurrentCtrl = speedState && (fastTick || slowTick);
    assign runSpeedCtrl = (r.state == ST_HIGH) && slowTick;
    assign runEstimator = (r.state != ST_STOP && r.state != ST_FREE && r.state != ST_FAULT) && fastTick;
    assign runActuation = r.actStrobe;
    assign diagFull = (r.state == ST_HIGH);
    assign diagBasic = 1'b1;
    assign slotIndex = r.slot;
    assign currentA = signed'(r.curA);
    assign currentB = signed'(r.curB);
    assign currentC = signed'(r.curC);

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstSync);

    sequence stopInHigh;
        r.state == ST_HIGH && r.stopReq && fastTick && !diagFault;
    endsequence

    AST_HIGH_TO_FREE: assert property (stopInHigh |=> r.state == ST_FREE && r.coast == $past(r.coastCfg))
        else $error("stop in high speed did not enter freewheel");
    AST_FAULT_ENTRY: assert property (fastTick && diagFault && (r.state == ST_HIGH || r.state == ST_FREE)
        |=> r.state == ST_FAULT && r.coast == 16'd0 && r.calDone == '0)
        else $error("fault not entered");
    AST_FAULT_PWM_OFF: assert property (diagFault |-> !pwmEnable)
        else $error("pwm enabled during fault");
    AST_SPEED_HIGH: assert property (slowTick && r.state == ST_HIGH |-> runSpeedCtrl && diagFull)
        else $error("speed control missing in high speed");
    AST_FREE_QUIET: assert property (r.state == ST_FREE |-> !pwmEnable && !runCurrentCtrl && !runEstimator
        && !diagFull)
        else $error("freewheel not quiet");
    AST_COAST_END: assert property (r.state == ST_FREE && fastTick && !diagFault && r.coast <= 16'd1
        |=> r.state == ST_STOP && r.calDone == '0)
        else $error("coast end did not stop");
    AST_COAST_DEC: assert property (r.state == ST_FREE && fastTick && !diagFault && r.coast > 16'd1
        |=> r.coast == $past(r.coast) - 16'd1)
        else $error("coast count not decremented");
    AST_SUM_ZERO: assert property (fastTick |=> r.curA + r.curB + r.curC == '0)
        else $error("phase currents do not sum to zero");
    AST_SLOT_ADV: assert property (smpValid && !fastTick && r.slot < 4'd9
        |=> r.slot == $past(r.slot) + 4'd1)
        else $error("slot did not advance");
    AST_OFFSET_SUB: assert property (fastTick && r.state == ST_STOP
        |=> r.curA == CW'({2'b00, $past(r.smp[0])}) - CW'({2'b00, $past(r.smp[2])}))
        else $error("runtime offset not removed");
    AST_NO_TICK_HOLD: assert property (!fastTick && !diagFault |=> r.state == $past(r.state))
        else $error("state changed without fast tick");
    AST_STOP_IDLE: assert property (r.state == ST_STOP |-> !pwmEnable)
        else $error("pwm enabled in stop");
    AST_ACK_ONE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not single cycle");

    sequence startInStop;
        r.state == ST_STOP && r.startReq && fastTick && !diagFault;
    endsequence

    sequence firstCalTick;
        fastTick && r.state == ST_ALIGN && activeVector != `MFS_VEC_BOTTOM && !diagFault && r.calDone == '0;
    endsequence

    AST_STOP_TO_ALIGN: assert property (startInStop |=> r.state == ST_ALIGN && r.calDone == '0)
        else $error("start request did not enter alignment");
    AST_CAL_RECORD: assert property (firstCalTick |=> $countones(r.calDone) == 1)
        else $error("first sector offset not recorded");
    AST_FAULT_HOLD: assert property (fastTick && diagFault && r.state == ST_FAULT |=> r.state == ST_FAULT)
        else $error("fault state left while fault present");
    AST_ACT_STROBE: assert property (fastTick && speedState |=> runActuation)
        else $error("actuation not strobed in speed state");
    AST_SLOT_RESTART: assert property (fastTick && smpValid |=> r.slot == 4'd1 && r.smp[0] == $past(smpData))
        else $error("period did not restart at slot zero");
    AST_SPEED_OFFSET: assert property (fastTick && speedState
        |=> r.curA == CW'({2'b00, $past(r.smp[0])}) - CW'({2'b00, $past(r.smp[2])}) - $past(r.offs[0][secI]))
        else $error("startup offset not removed");
    AST_CUR_HOLD: assert property (!fastTick |=> r.curA == $past(r.curA) && r.curC == $past(r.curC))
        else $error("currents changed without fast tick");
    AST_CAL_DRIVE: assert property (r.state == ST_ALIGN && !(&r.calDone) |-> calDrive50)
        else $error("calibration drive missing");
    AST_HIGH_RUN: assert property (r.state == ST_HIGH && fastTick |-> runCurrentCtrl && runEstimator && diagFull)
        else $error("high speed loops not running");
    AST_IDLE_QUIET: assert property (r.state == ST_STOP |-> !runEstimator && !runCurrentCtrl)
        else $error("loops running in stop");
endmodule
